//--- logic/tpw_inverter_pwm.sv
/*
 * Three-phase inverter waveform generator: timing unit, output control,
 * gate-drive chopper, sync pin control, shutdown and Avalon-MM registers.
 * Assumes one core clock, synchronous inputs and a synchronous reset.
 */
// What this block does
// - six gate outputs, three high/low pairs
// - complementary centre-aligned dead-time adjusted pairs
// - per-output enable bit, cleared means off
// - per-pair crossover swaps high and low
// - chopper frequency from 8-bit config field
// - separate chop enables for high, low sides
// - single update: one sync, reload per period
// - double update: extra midpoint sync and reload
// - internal sync pin pulse, width from register
// - control bit picks driving or accepting sync
// - control bit selects external sync synchroniser
// - trip low forces outputs high, unclocked
// - trip shutdown resets the timing unit
// - status shows trip input level
// - status shows first or second half
// - interrupt per sync, another on shutdown
// - all timing runs on core clock
// - half-period register counts clocks per half
// - one 10-bit dead time, times two
// - control bit 2 double update, reset single
// - timing outputs active low
`timescale 1ns/1ps
`include "tpw_map.svh"

module tpw_inverter_pwm
    import tpw_pkg::*;
(
    input  wire logic         CLK_IN,
    input  wire logic         RST_IN,
    input  wire logic [5:0]   AVS_ADDRESS_IN,
    input  wire logic         AVS_READ_IN,
    input  wire logic         AVS_WRITE_IN,
    input  wire logic [31:0]  AVS_WRITEDATA_IN,
    input  wire logic [3:0]   AVS_BYTEENABLE_IN,
    output logic [31:0]       AVS_READDATA_OUT,
    output logic              AVS_WAITREQUEST_OUT,
    input  wire logic         SHUTDOWN_TRIP_N_IN,
    input  wire logic         SYNC_PIN_IN,
    output logic              SYNC_PIN_OUT,
    output logic              SYNC_PIN_OE_OUT,
    output logic              PHASE_A_HIGH_OUT,
    output logic              PHASE_A_LOW_OUT,
    output logic              PHASE_B_HIGH_OUT,
    output logic              PHASE_B_LOW_OUT,
    output logic              PHASE_C_HIGH_OUT,
    output logic              PHASE_C_LOW_OUT,
    output logic              SYNC_IRQ_OUT,
    output logic              TRIP_IRQ_OUT
);

    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return r;
    endfunction : merge_be

    ////////////////////////////////////////////////////////////////////////
    // register bus
    tpw_bus_state_type bus_q, bus_d;
    tpw_regs_type      regs_q, regs_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              waitreq_q, waitreq_d;
    logic [31:0]       rd_word;
    logic [31:0]       wr_word;
    logic              half_q;
    logic              trip_q;

    always_comb begin
        case (AVS_ADDRESS_IN)
            `TPW_OFF_CONTROL:     rd_word = 32'(regs_q.ctrl);
            `TPW_OFF_STATUS:      rd_word = 32'({trip_q, half_q});
            `TPW_OFF_HALF_PERIOD: rd_word = 32'(regs_q.half_period);
            `TPW_OFF_DEAD_TIME:   rd_word = 32'(regs_q.dead_time);
            `TPW_OFF_SYNC_WIDTH:  rd_word = 32'(regs_q.sync_width);
            `TPW_OFF_DUTY_A:      rd_word = 32'(regs_q.duty[0]);
            `TPW_OFF_DUTY_B:      rd_word = 32'(regs_q.duty[1]);
            `TPW_OFF_DUTY_C:      rd_word = 32'(regs_q.duty[2]);
            `TPW_OFF_GATE_EN:     rd_word = 32'(regs_q.gate_en);
            `TPW_OFF_CHOPPER:     rd_word = 32'(regs_q.chop_cfg);
            default:              rd_word = 32'h0000_0000;
        endcase
        wr_word = merge_be(rd_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end

    // answer one cycle after the request; a write lands at the edge
    // where the master sees waitrequest low
    always_comb begin
        bus_d     = bus_q;
        regs_d    = regs_q;
        rdata_d   = rdata_q;
        waitreq_d = 1'b1;
        unique case (bus_q)
            TPW_BUS_WAIT: begin
                if (AVS_READ_IN || AVS_WRITE_IN) begin
                    bus_d     = TPW_BUS_DONE;
                    waitreq_d = 1'b0;
                    if (AVS_READ_IN) begin
                        rdata_d = rd_word;
                    end
                end
            end
            TPW_BUS_DONE: begin
                bus_d = TPW_BUS_WAIT;
                if (AVS_WRITE_IN) begin
                    case (AVS_ADDRESS_IN)
                        `TPW_OFF_CONTROL:     regs_d.ctrl        = wr_word[3:0];
                        `TPW_OFF_HALF_PERIOD: regs_d.half_period = wr_word[15:0];
                        `TPW_OFF_DEAD_TIME:   regs_d.dead_time   = wr_word[9:0];
                        `TPW_OFF_SYNC_WIDTH:  regs_d.sync_width  = wr_word[15:0];
                        `TPW_OFF_DUTY_A:      regs_d.duty[0]     = wr_word[15:0];
                        `TPW_OFF_DUTY_B:      regs_d.duty[1]     = wr_word[15:0];
                        `TPW_OFF_DUTY_C:      regs_d.duty[2]     = wr_word[15:0];
                        `TPW_OFF_GATE_EN:     regs_d.gate_en     = wr_word[8:0];
                        `TPW_OFF_CHOPPER:     regs_d.chop_cfg    = wr_word[9:0];
                        default:              regs_d             = regs_q;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            bus_q              <= TPW_BUS_WAIT;
            waitreq_q          <= 1'b1;
            rdata_q            <= 32'h0000_0000;
            regs_q.ctrl        <= `TPW_RST_CONTROL;
            regs_q.half_period <= `TPW_RST_HALF_PERIOD;
            regs_q.dead_time   <= `TPW_RST_DEAD_TIME;
            regs_q.sync_width  <= `TPW_RST_SYNC_WIDTH;
            regs_q.duty        <= {3{`TPW_RST_DUTY}};
            regs_q.gate_en     <= `TPW_RST_GATE_EN;
            regs_q.chop_cfg    <= `TPW_RST_CHOPPER;
        end else begin
            bus_q     <= bus_d;
            waitreq_q <= waitreq_d;
            rdata_q   <= rdata_d;
            regs_q    <= regs_d;
        end
    end

    assign AVS_READDATA_OUT    = rdata_q;
    assign AVS_WAITREQUEST_OUT = waitreq_q;

    ////////////////////////////////////////////////////////////////////////
    // sync pin input; first stage feeds only the second
    logic sy1_q, sy2_q, sy3_q, sraw_q;
    logic ext_edge;
    logic ext_accept;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            sy1_q  <= 1'b0;
            sy2_q  <= 1'b0;
            sy3_q  <= 1'b0;
            sraw_q <= 1'b0;
        end else begin
            sy1_q  <= SYNC_PIN_IN;
            sy2_q  <= sy1_q;
            sy3_q  <= sy2_q;
            sraw_q <= SYNC_PIN_IN;
        end
    end

    // pulses of three or more clocks are never missed by either path
    assign ext_edge   = regs_q.ctrl[`TPW_CTRL_RESYNC] ? (sy2_q & ~sy3_q)
                                                      : (SYNC_PIN_IN & ~sraw_q);
    assign ext_accept = regs_q.ctrl[`TPW_CTRL_EXT_SYNC] & ext_edge;

    ////////////////////////////////////////////////////////////////////////
    // half-period counter, sync events, shadow reload
    tpw_shadow_type sh_q, sh_d, sh_load;
    logic [15:0]    cnt_q, cnt_d;
    logic           half_d;
    logic           psync_q, psync_d;
    logic           timer_rst;
    logic           last_tick;

    assign timer_rst = ~trip_q | ~regs_q.ctrl[`TPW_CTRL_RUN];
    // half periods of 0 or 1 are not meaningful; 1 wraps every clock, 0 counts 65536 clocks
    assign last_tick = cnt_q >= (sh_q.half_period - 16'h0001);
    assign sh_load   = '{half_period: regs_q.half_period, dead_time: regs_q.dead_time,
                         duty: regs_q.duty, gate_en: regs_q.gate_en};

    always_comb begin
        cnt_d   = cnt_q + 16'h0001;
        half_d  = half_q;
        psync_d = 1'b0;
        sh_d    = sh_q;
        if (timer_rst) begin
            cnt_d  = 16'h0000;
            half_d = 1'b0;
            sh_d   = sh_load;
        end else if (ext_accept) begin
            cnt_d   = 16'h0000;
            half_d  = 1'b0;
            psync_d = 1'b1;
            sh_d    = sh_load;
        end else if (last_tick) begin
            cnt_d   = 16'h0000;
            half_d  = ~half_q;
            psync_d = half_q | regs_q.ctrl[`TPW_CTRL_DOUBLE];
            if (psync_d) begin
                sh_d = sh_load;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            cnt_q   <= 16'h0000;
            half_q  <= 1'b0;
            psync_q <= 1'b0;
            sh_q    <= '{half_period: `TPW_RST_HALF_PERIOD, dead_time: `TPW_RST_DEAD_TIME,
                         duty: {3{`TPW_RST_DUTY}}, gate_en: `TPW_RST_GATE_EN};
        end else begin
            cnt_q   <= cnt_d;
            half_q  <= half_d;
            psync_q <= psync_d;
            sh_q    <= sh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync pin output, interrupts, trip sampling
    logic [15:0] wid_q, wid_d;
    logic        sync_out_q, sync_oe_q, sync_irq_q, trip_irq_q;

    always_comb begin
        if (psync_q) begin
            wid_d = regs_q.sync_width;
        end else if (wid_q != 16'h0000) begin
            wid_d = wid_q - 16'h0001;
        end else begin
            wid_d = 16'h0000;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            wid_q      <= 16'h0000;
            sync_out_q <= 1'b0;
            sync_oe_q  <= 1'b0;
            sync_irq_q <= 1'b0;
            trip_irq_q <= 1'b0;
            trip_q     <= 1'b1;
        end else begin
            wid_q      <= wid_d;
            sync_out_q <= (wid_d != 16'h0000) & ~regs_q.ctrl[`TPW_CTRL_EXT_SYNC];
            sync_oe_q  <= ~regs_q.ctrl[`TPW_CTRL_EXT_SYNC];
            sync_irq_q <= psync_q;
            trip_irq_q <= trip_q & ~SHUTDOWN_TRIP_N_IN;
            trip_q     <= SHUTDOWN_TRIP_N_IN;
        end
    end

    assign SYNC_PIN_OUT    = sync_out_q;
    assign SYNC_PIN_OE_OUT = sync_oe_q;
    assign SYNC_IRQ_OUT    = sync_irq_q;
    assign TRIP_IRQ_OUT    = trip_irq_q;

    ////////////////////////////////////////////////////////////////////////
    // timing unit, crossover, chopper, enables
    logic [7:0] chop_cnt_q, chop_cnt_d;
    logic       chop_q, chop_d;
    logic [2:0] hi_n, lo_n;
    logic [5:0] drv_q, drv_d;

    always_comb begin
        chop_cnt_d = chop_cnt_q + 8'h01;
        chop_d     = chop_q;
        if (chop_cnt_q >= regs_q.chop_cfg[7:0]) begin
            chop_cnt_d = 8'h00;
            chop_d     = ~chop_q;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_phase
        logic hi_x, lo_x, hi_c, lo_c;

        tpw_phase_timer #(
            .CNT_W (16),
            .DT_W  (10)
        ) u_timer (
            .clk_in         (CLK_IN),
            .rst_in         (RST_IN | timer_rst),
            .half_in        (half_q),
            .count_in       (cnt_q),
            .half_period_in (sh_q.half_period),
            .duty_in        (sh_q.duty[i]),
            .dead_time_in   (sh_q.dead_time),
            .hi_n_out       (hi_n[i]),
            .lo_n_out       (lo_n[i])
        );

        assign hi_x = sh_q.gate_en[`TPW_GATE_XOVER_LSB+i] ? lo_n[i] : hi_n[i];
        assign lo_x = sh_q.gate_en[`TPW_GATE_XOVER_LSB+i] ? hi_n[i] : lo_n[i];
        // active-low drive: on only while the chop wave is high
        assign hi_c = hi_x | (regs_q.chop_cfg[`TPW_CHOP_HI_EN] & ~chop_q);
        assign lo_c = lo_x | (regs_q.chop_cfg[`TPW_CHOP_LO_EN] & ~chop_q);
        assign drv_d[2*i]   = hi_c | ~sh_q.gate_en[2*i];
        assign drv_d[2*i+1] = lo_c | ~sh_q.gate_en[2*i+1];
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            chop_cnt_q <= 8'h00;
            chop_q     <= 1'b0;
            drv_q      <= 6'h3F;
        end else begin
            chop_cnt_q <= chop_cnt_d;
            chop_q     <= chop_d;
            drv_q      <= drv_d;
        end
    end

    // trip bypasses every flop so shutdown holds with a dead clock
    assign PHASE_A_HIGH_OUT = drv_q[0] | ~SHUTDOWN_TRIP_N_IN;
    assign PHASE_A_LOW_OUT  = drv_q[1] | ~SHUTDOWN_TRIP_N_IN;
    assign PHASE_B_HIGH_OUT = drv_q[2] | ~SHUTDOWN_TRIP_N_IN;
    assign PHASE_B_LOW_OUT  = drv_q[3] | ~SHUTDOWN_TRIP_N_IN;
    assign PHASE_C_HIGH_OUT = drv_q[4] | ~SHUTDOWN_TRIP_N_IN;
    assign PHASE_C_LOW_OUT  = drv_q[5] | ~SHUTDOWN_TRIP_N_IN;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    a_trip_forces_off: assert property (
        !SHUTDOWN_TRIP_N_IN |-> (PHASE_A_HIGH_OUT && PHASE_A_LOW_OUT && PHASE_B_HIGH_OUT
                                 && PHASE_B_LOW_OUT && PHASE_C_HIGH_OUT && PHASE_C_LOW_OUT))
        else $error("trip low but an output is on");

    a_trip_stops_timer: assert property (
        !SHUTDOWN_TRIP_N_IN |=> ##1 (cnt_q == 16'h0000 && !half_q) ##1 drv_q == 6'h3F)
        else $error("timing unit not reset by trip");

    a_disabled_stays_off: assert property (
        !sh_q.gate_en[3] |=> drv_q[3])
        else $error("disabled output drove on");

    a_crossover_swaps: assert property (
        (sh_q.gate_en[6] && sh_q.gate_en[0] && !regs_q.chop_cfg[`TPW_CHOP_HI_EN])
        |=> drv_q[0] == $past(lo_n[0]))
        else $error("crossover did not route low waveform to high output");

    a_chop_gates_high: assert property (
        (regs_q.chop_cfg[`TPW_CHOP_HI_EN] && !chop_q) |=> drv_q[0] && drv_q[2] && drv_q[4])
        else $error("high side on while chop wave low");

    a_single_sync_start: assert property (
        (psync_q && !$past(regs_q.ctrl[`TPW_CTRL_DOUBLE])) |-> !half_q)
        else $error("single update sync outside period start");

    a_double_mid_sync: assert property (
        (regs_q.ctrl[`TPW_CTRL_DOUBLE] && last_tick && !half_q && !timer_rst && !ext_accept)
        |=> psync_q && half_q && sh_q.duty == $past(regs_q.duty))
        else $error("double update midpoint sync or reload missing");

    // a switch to external sync mid-pulse cuts the pulse short on purpose
    a_sync_pin_pulse: assert property (
        disable iff (RST_IN || regs_q.ctrl[`TPW_CTRL_EXT_SYNC])
        (psync_q && regs_q.sync_width == 16'h0004)
        |=> SYNC_PIN_OUT [*4] ##1 !SYNC_PIN_OUT)
        else $error("sync pin pulse width wrong");

    a_ext_releases_pin: assert property (
        regs_q.ctrl[`TPW_CTRL_EXT_SYNC] |=> !SYNC_PIN_OE_OUT)
        else $error("sync pin driven while external sync selected");

    a_ext_restart: assert property (
        (ext_accept && !timer_rst) |=> cnt_q == 16'h0000 && !half_q && psync_q)
        else $error("external sync did not restart the period");

    a_status_read: assert property (
        (bus_q == TPW_BUS_WAIT && AVS_READ_IN && AVS_ADDRESS_IN == `TPW_OFF_STATUS)
        |=> !AVS_WAITREQUEST_OUT && AVS_READDATA_OUT[1:0] == $past({trip_q, half_q}))
        else $error("status read wrong");

    a_irqs_follow: assert property (
        (psync_q |=> SYNC_IRQ_OUT) and ((trip_q && !SHUTDOWN_TRIP_N_IN) |=> TRIP_IRQ_OUT))
        else $error("interrupt pulse missing");

    c_double_mid: cover property (psync_q && half_q);
    c_ext_restart: cover property (ext_accept && !timer_rst);
    c_trip_hit: cover property (TRIP_IRQ_OUT);
    c_chop_on: cover property (regs_q.chop_cfg[`TPW_CHOP_LO_EN] && !drv_q[1]);

endmodule : tpw_inverter_pwm

//--- logic/tpw_map.svh
/*
 * Register offsets, field positions and reset values of the three-phase
 * inverter waveform generator.
 * Assumes byte addresses on a 32-bit Avalon-MM slave, one word per register.
 */
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

// byte offsets
`define TPW_OFF_CONTROL      6'h00
`define TPW_OFF_STATUS       6'h04
`define TPW_OFF_HALF_PERIOD  6'h08
`define TPW_OFF_DEAD_TIME    6'h0C
`define TPW_OFF_SYNC_WIDTH   6'h10
`define TPW_OFF_DUTY_A       6'h14
`define TPW_OFF_DUTY_B       6'h18
`define TPW_OFF_DUTY_C       6'h1C
`define TPW_OFF_GATE_EN      6'h20
`define TPW_OFF_CHOPPER      6'h24

// waveform_control bits
`define TPW_CTRL_RUN         0
`define TPW_CTRL_EXT_SYNC    1
`define TPW_CTRL_DOUBLE      2
`define TPW_CTRL_RESYNC      3

// waveform_status bits
`define TPW_STAT_HALF        0
`define TPW_STAT_TRIP        1

// output_gate_enables: bits 5..0 enables, bits 8..6 crossover
`define TPW_GATE_XOVER_LSB   6

// chopper_config bits
`define TPW_CHOP_HI_EN       8
`define TPW_CHOP_LO_EN       9

// reset values
`define TPW_RST_CONTROL      4'h0
`define TPW_RST_HALF_PERIOD  16'h0100
`define TPW_RST_DEAD_TIME    10'h000
`define TPW_RST_SYNC_WIDTH   16'h0004
`define TPW_RST_DUTY         16'h0000
`define TPW_RST_GATE_EN      9'h000
`define TPW_RST_CHOPPER      10'h000

`endif

//--- logic/tpw_phase_timer.sv
/*
 * One phase of the timing unit: centre-based complementary pair with
 * dead time, active low.
 * Assumes count/half come from a shared half-period counter.
 */
`timescale 1ns/1ps

module tpw_phase_timer #(
    parameter int CNT_W = 16,
    parameter int DT_W  = 10
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              half_in,
    input  wire logic [CNT_W-1:0]  count_in,
    input  wire logic [CNT_W-1:0]  half_period_in,
    input  wire logic [CNT_W-1:0]  duty_in,
    input  wire logic [DT_W-1:0]   dead_time_in,
    output logic                   hi_n_out,
    output logic                   lo_n_out
);

    logic [CNT_W+1:0] pos;
    logic [CNT_W+1:0] hp;
    logic [CNT_W+1:0] duty;
    logic [CNT_W+1:0] dt;
    logic             hi_on;
    logic             lo_on;
    logic             hi_n_d;
    logic             lo_n_d;
    logic             hi_n_q;
    logic             lo_n_q;

    assign pos  = (CNT_W+2)'(count_in);
    assign hp   = (CNT_W+2)'(half_period_in);
    assign duty = (CNT_W+2)'(duty_in);
    assign dt   = (CNT_W+2)'(dead_time_in);

    ////////////////////////////////////////////////////////////////////////
    // both edges move dt away from the duty instant, so the gap is 2*dt
    always_comb begin
        if (!half_in) begin
            hi_on = (pos + duty) >= (hp + dt);
            lo_on = (pos + duty + dt) < hp;
        end else begin
            hi_on = (pos + dt) < duty;
            lo_on = pos >= (duty + dt);
        end
        hi_n_d = ~hi_on;
        lo_n_d = ~lo_on;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hi_n_q <= 1'b1;
            lo_n_q <= 1'b1;
        end else begin
            hi_n_q <= hi_n_d;
            lo_n_q <= lo_n_d;
        end
    end

    assign hi_n_out = hi_n_q;
    assign lo_n_out = lo_n_q;

    a_pair_never_both: assert property (
        @(posedge clk_in) disable iff (rst_in) !(!hi_n_q && !lo_n_q))
        else $error("high and low side of one pair both on");

endmodule : tpw_phase_timer

//--- logic/tpw_pkg.sv
/*
 * Types of the three-phase inverter waveform generator.
 * Assumes tpw_map.svh supplies the numeric constants.
 */
package tpw_pkg;

    typedef struct packed {
        logic [3:0]        ctrl;
        logic [15:0]       half_period;
        logic [9:0]        dead_time;
        logic [15:0]       sync_width;
        logic [2:0][15:0]  duty;
        logic [8:0]        gate_en;
        logic [9:0]        chop_cfg;
    } tpw_regs_type;

    typedef struct packed {
        logic [15:0]       half_period;
        logic [9:0]        dead_time;
        logic [2:0][15:0]  duty;
        logic [8:0]        gate_en;
    } tpw_shadow_type;

    typedef enum logic {
        TPW_BUS_WAIT = 1'b0,
        TPW_BUS_DONE = 1'b1
    } tpw_bus_state_type;

endpackage : tpw_pkg

//--- testbench/tb_tpw_inverter_pwm.sv
/* bench of the inverter waveform generator over its Avalon-MM port.
   assumes tpw_gate_model on the gate pins and as external sync source. */
`timescale 1ns/1ps
module tb_tpw_inverter_pwm;
    logic clk = 0, rst = 1, rd = 0, wr = 0, trip_n = 1, fire = 0, ext_sync, shoot, oe, sp;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, q;
    logic [5:0] g;
    logic wt, sirq, tirq;
    int miscompares = 0, n_checks = 0, cyc = 0, ni, nsp, nlo, nsh, nt;
    initial forever #12.5 clk = ~clk;
    tpw_inverter_pwm i_dut (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt),
        .SHUTDOWN_TRIP_N_IN(trip_n), .SYNC_PIN_IN(oe ? sp : ext_sync),
        .SYNC_PIN_OUT(sp), .SYNC_PIN_OE_OUT(oe), .PHASE_A_HIGH_OUT(g[0]),
        .PHASE_A_LOW_OUT(g[1]), .PHASE_B_HIGH_OUT(g[2]), .PHASE_B_LOW_OUT(g[3]),
        .PHASE_C_HIGH_OUT(g[4]), .PHASE_C_LOW_OUT(g[5]), .SYNC_IRQ_OUT(sirq),
        .TRIP_IRQ_OUT(tirq));
    tpw_gate_model i_gate (.clk_in(clk), .gate_n_in(g), .fire_in(fire),
        .sync_out(ext_sync), .shoot_out(shoot));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        rd <= 0; wr <= 0;
    endtask : bus
    // counts over n cycles; a whole number of periods gives exact totals
    task automatic win(input int n);
        ni = 0; nsp = 0; nlo = 0; nsh = 0; nt = 0;
        repeat (n) begin
            @(negedge clk);
            ni += sirq; nsp += sp; nlo += !g[0]; nsh += shoot; nt += tirq;
        end
    endtask : win
    always @(posedge clk) if (++cyc == 20000) begin miscompares++; report_and_stop(); end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        chk("gates idle", 32'(g), 32'h3F);
        bus(0, 6'h00, 0); chk("control", q, 32'h0);
        bus(0, 6'h08, 0); chk("half period", q, 32'h0100);
        bus(0, 6'h10, 0); chk("sync width", q, 32'h4);
        chk("pin driven", 32'(oe), 32'h1);
        bus(0, 6'h3C, 0); chk("unmapped", q, 32'h0);
        bus(1, 6'h08, 32'h8); bus(1, 6'h0C, 32'h1);
        bus(1, 6'h14, 32'h4); bus(1, 6'h18, 32'h4); bus(1, 6'h1C, 32'h4);
        bus(1, 6'h20, 32'h3F); bus(1, 6'h00, 32'h1);
        repeat (40) @(posedge clk);
        win(160);
        chk("single syncs", ni, 10);
        chk("pin width", nsp, 40);
        chk("overlap", nsh, 0);
        chk("a high on", nlo, 10 * 2 * (4 - 1));
        bus(1, 6'h00, 32'h5); repeat (40) @(posedge clk);
        win(160); chk("double syncs", ni, 20);
        bus(1, 6'h20, 32'h3E); repeat (40) @(posedge clk);
        win(160); chk("a high off", nlo, 0);
        bus(1, 6'h14, 32'h6); bus(1, 6'h20, 32'h7F); repeat (40) @(posedge clk);
        win(160); chk("a crossed", nlo, 10 * 2 * (8 - 6 - 1));
        bus(1, 6'h14, 32'h5); bus(1, 6'h20, 32'h3F); bus(1, 6'h24, 32'h301);
        repeat (40) @(posedge clk);
        win(160); chk("a chopped", nlo, 10 * 2 * (5 - 1) / 2);
        chk("chop overlap", nsh, 0);
        bus(1, 6'h24, 32'h0); repeat (40) @(posedge clk);
        @(posedge clk) trip_n <= 0;
        #1 chk("tripped", 32'(g), 32'h3F);
        win(40); chk("trip irq", nt, 1);
        chk("trip hold", nlo, 0);
        bus(0, 6'h04, 0); chk("trip bit", q[1], 1'b0);
        chk("half bit", q[0], 1'b0);
        @(posedge clk) trip_n <= 1;
        bus(1, 6'h08, 32'h0100); bus(1, 6'h00, 32'h3); repeat (600) @(posedge clk);
        chk("pin released", 32'(oe), 32'h0);
        fire <= 1; @(posedge clk) fire <= 0;
        win(6); chk("ext sync", 32'(ni != 0), 1);
        bus(1, 6'h00, 32'hB); repeat (20) @(posedge clk);
        fire <= 1; @(posedge clk) fire <= 0;
        win(8); chk("resync sync", ni, 1);
        report_and_stop();
    end
endmodule : tb_tpw_inverter_pwm

//--- testbench/tpw_gate_model.sv
/* gate driver and external sync source model.
   assumes active low gate drives and the core clock of the bench. */
`timescale 1ns/1ps
module tpw_gate_model (
    input  wire logic       clk_in,
    input  wire logic [5:0] gate_n_in,
    input  wire logic       fire_in,
    output logic            sync_out,
    output logic            shoot_out
);
    logic [1:0] left_q = 2'h0;
    // three clocks: either path would catch even a one-clock pulse
    always_ff @(posedge clk_in)
        left_q <= fire_in ? 2'h3 : (left_q != 2'h0 ? left_q - 2'h1 : 2'h0);
    assign sync_out  = (left_q != 2'h0);
    // both switches of one leg on shorts the link
    assign shoot_out = (~gate_n_in[0] & ~gate_n_in[1]) | (~gate_n_in[2] & ~gate_n_in[3])
                     | (~gate_n_in[4] & ~gate_n_in[5]);
endmodule : tpw_gate_model
